// >>> design/ofadc_core.sv
// Operation
// - Switch mode: one switch off/hold for all
// - Software mode: per-channel off, hold, on
// - Analogue bytes low first, high if selected
// - Control supply monitor error, enabled by default
// - Output supply monitor error, disabled by default
// - Short detection raises error when enabled
// - Auto restart clears error when short gone
// - Manual restart latches error until reset
// - Per-channel open detection, default disabled
// - Comm fault drives channel per setting
// - Comm idle drives channel per setting
// - Per-channel fault/idle actions only in software mode
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
module ofadc_core #(
  parameter int NCH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Avalon-MM slave
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Pins from monitors and switch
  input wire ofadc_pkg::ofadc_supply_t i_supply,
  input wire logic i_short,
  input wire logic [NCH-1:0] i_open,
  input wire logic i_hold_switch,
  // Communication state from network side
  input wire logic i_comm_fault,
  input wire logic i_comm_idle,
  input wire logic [NCH-1:0] i_out_cmd,
  // Analogue word to controller
  input wire logic [15:0] i_analog,
  output logic [15:0] o_analog,
  // Outputs
  output logic [NCH-1:0] o_valve,
  output logic [ofadc_pkg::DIAG_W-1:0] o_diag,
  output logic [NCH-1:0] o_open_err,
  output logic o_irq
);
  import ofadc_pkg::*;

  logic [CTRL_W-1:0] ctrl;
  logic [NCH-1:0] open_en;
  logic [2*NCH-1:0] fault_act;
  logic [2*NCH-1:0] idle_act;
  logic [DIAG_W-1:0] irq_stat;
  logic [DIAG_W-1:0] irq_mask;
  logic [DIAG_W-1:0] diag_prev;
  logic short_latch;
  logic ack;
  ofadc_comm_t comm;
  ofadc_supply_t sup_m, sup_s;
  logic short_m, short_s, sw_m, sw_s;
  logic flt_m, flt_s, idl_m, idl_s;
  logic [NCH-1:0] open_m, open_s;
  logic [DIAG_W-1:0] next_diag;
  logic [NCH-1:0] next_valve;
  logic [NCH-1:0] next_open;

  // Two-flop synchronisers for pin inputs
  always_ff @(posedge i_clk) begin
    sup_m <= i_supply;
    sup_s <= sup_m;
    short_m <= i_short;
    short_s <= short_m;
    sw_m <= i_hold_switch;
    sw_s <= sw_m;
    flt_m <= i_comm_fault;
    flt_s <= flt_m;
    idl_m <= i_comm_idle;
    idl_s <= idl_m;
    open_m <= i_open;
    open_s <= open_m;
  end

  // One wait cycle per access keeps read data registered
  assign o_waitrequest = (i_read | i_write) & ~ack;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (i_read | i_write) & ~ack;
    end
  end

  // Configuration registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl <= CTRL_RESET;
      open_en <= '0;
      fault_act <= '0;
      idle_act <= '0;
      irq_mask <= '0;
    end else if (i_write && ack) begin
      case (i_address)
        ADDR_CTRL: ctrl <= i_writedata[CTRL_W-1:0];
        ADDR_OPEN_EN: open_en <= i_writedata[NCH-1:0];
        ADDR_FAULT_ACT: fault_act <= i_writedata[2*NCH-1:0];
        ADDR_IDLE_ACT: idle_act <= i_writedata[2*NCH-1:0];
        ADDR_IRQ_MASK: irq_mask <= i_writedata[DIAG_W-1:0];
        default: ;
      endcase
    end
  end

  // Communication state; a fault outranks idle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      comm <= OFADC_RUN;
    end else if (flt_s) begin
      comm <= OFADC_FAULT;
    end else if (idl_s) begin
      comm <= OFADC_IDLE;
    end else begin
      comm <= OFADC_RUN;
    end
  end

  // Manual restart latch survives until reset only
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      short_latch <= 1'b0;
    end else if (short_s && ctrl[CTRL_SHORT_EN] && ctrl[CTRL_MANUAL]) begin
      short_latch <= 1'b1;
    end
  end

  always_comb begin
    next_diag = '0;
    next_diag[DIAG_CI] = ctrl[CTRL_CI_MON]
      & (sup_s.ci_high | sup_s.ci_low);
    next_diag[DIAG_OUT] = ctrl[CTRL_OUT_MON]
      & (sup_s.out_high | sup_s.out_low);
    next_diag[DIAG_SHORT] = ctrl[CTRL_SHORT_EN]
      & (short_s | short_latch);
    next_open = open_s & open_en;
    next_diag[DIAG_OPEN] = |next_open;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_diag <= '0;
      o_open_err <= '0;
      diag_prev <= '0;
    end else begin
      o_diag <= next_diag;
      o_open_err <= next_open;
      diag_prev <= o_diag;
    end
  end

  // Sticky status: new rising error wins over the read clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= ((i_read && ack && i_address == ADDR_IRQ_STAT)
        ? '0 : irq_stat) | (o_diag & ~diag_prev);
    end
  end

  assign o_irq = |(irq_stat & irq_mask);

  // Output action per channel
  always_comb begin
    logic [1:0] act;
    act = ACT_OFF;
    next_valve = i_out_cmd;
    for (int c = 0; c < NCH; c++) begin
      act = (comm == OFADC_FAULT) ? fault_act[2*c +: 2] : idle_act[2*c +: 2];
      if (comm != OFADC_RUN) begin
        if (!ctrl[CTRL_PRIO_SW]) begin
          next_valve[c] = sw_s & o_valve[c];
        end else begin
          case (act)
            ACT_HOLD: next_valve[c] = o_valve[c];
            ACT_ON: next_valve[c] = 1'b1;
            default: next_valve[c] = 1'b0;
          endcase
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_valve <= '0;
    end else begin
      o_valve <= next_valve;
    end
  end

  // Byte order of analogue values
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_analog <= '0;
    end else if (ctrl[CTRL_BYTE_HI]) begin
      o_analog <= {i_analog[7:0], i_analog[15:8]};
    end else begin
      o_analog <= i_analog;
    end
  end

  // Read data
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_readdata <= '0;
    end else if (i_read && !ack) begin
      case (i_address)
        ADDR_CTRL: o_readdata <= 32'(ctrl);
        ADDR_OPEN_EN: o_readdata <= 32'(open_en);
        ADDR_FAULT_ACT: o_readdata <= 32'(fault_act);
        ADDR_IDLE_ACT: o_readdata <= 32'(idle_act);
        ADDR_DIAG: o_readdata <= 32'({o_open_err, o_diag});
        ADDR_IRQ_STAT: o_readdata <= 32'(irq_stat);
        ADDR_IRQ_MASK: o_readdata <= 32'(irq_mask);
        ADDR_OUT_STATE: o_readdata <= 32'(o_valve);
        default: o_readdata <= '0;
      endcase
    end
  end

  a_open_default: assert property (@(posedge i_clk)
    disable iff (i_rst)
    $rose(open_s[0]) && !open_en[0] |=> ##1 !o_open_err[0])
    else $error("open error without enable");

  a_open_flag: assert property (@(posedge i_clk)
    disable iff (i_rst)
    |(open_s & open_en) |=> o_diag[DIAG_OPEN])
    else $error("open error not flagged");

  a_manual_latch: assert property (@(posedge i_clk)
    disable iff (i_rst)
    o_diag[DIAG_SHORT] && ctrl[CTRL_MANUAL] && ctrl[CTRL_SHORT_EN]
    && $stable(ctrl) |=> o_diag[DIAG_SHORT])
    else $error("manual short error dropped");

  a_auto_clear: assert property (@(posedge i_clk)
    disable iff (i_rst)
    !short_s && !short_latch |=> !o_diag[DIAG_SHORT])
    else $error("auto short error stuck");

  a_short_raise: assert property (@(posedge i_clk)
    disable iff (i_rst)
    ctrl[CTRL_SHORT_EN] && short_s |=> o_diag[DIAG_SHORT])
    else $error("short error not raised");

  a_short_off: assert property (@(posedge i_clk)
    disable iff (i_rst)
    !ctrl[CTRL_SHORT_EN] |=> !o_diag[DIAG_SHORT])
    else $error("short error while disabled");

  a_irq_sticky: assert property (@(posedge i_clk)
    disable iff (i_rst)
    o_diag[DIAG_SHORT] && !diag_prev[DIAG_SHORT] |=> irq_stat[DIAG_SHORT])
    else $error("short status not set");

  a_force_on: assert property (@(posedge i_clk)
    disable iff (i_rst)
    comm == OFADC_FAULT && ctrl[CTRL_PRIO_SW] && fault_act[1:0] == ACT_ON
    |=> o_valve[0])
    else $error("forced on not driven");

  a_fault_hold: assert property (@(posedge i_clk)
    disable iff (i_rst)
    comm == OFADC_FAULT && ctrl[CTRL_PRIO_SW] && fault_act[3:2] == ACT_HOLD
    |=> o_valve[1] == $past(o_valve[1]))
    else $error("fault hold not kept");

  a_idle_off: assert property (@(posedge i_clk)
    disable iff (i_rst)
    comm == OFADC_IDLE && ctrl[CTRL_PRIO_SW] && idle_act[1:0] == ACT_OFF
    |=> !o_valve[0])
    else $error("idle off not driven");

  a_switch_clear: assert property (@(posedge i_clk)
    disable iff (i_rst)
    comm != OFADC_RUN && !ctrl[CTRL_PRIO_SW] && !sw_s |=> o_valve == '0)
    else $error("switch clear ignored");

  a_switch_hold: assert property (@(posedge i_clk)
    disable iff (i_rst)
    comm != OFADC_RUN && !ctrl[CTRL_PRIO_SW] && sw_s
    |=> o_valve == $past(o_valve))
    else $error("switch hold ignored");

  a_ci_monitor: assert property (@(posedge i_clk)
    disable iff (i_rst)
    !ctrl[CTRL_CI_MON] |=> !o_diag[DIAG_CI])
    else $error("ci error while disabled");

  a_ci_raise: assert property (@(posedge i_clk)
    disable iff (i_rst)
    ctrl[CTRL_CI_MON] && (sup_s.ci_high || sup_s.ci_low)
    |=> o_diag[DIAG_CI])
    else $error("ci error not raised");

  a_out_monitor: assert property (@(posedge i_clk)
    disable iff (i_rst)
    ctrl[CTRL_OUT_MON] && (sup_s.out_high || sup_s.out_low)
    |=> o_diag[DIAG_OUT])
    else $error("output supply error not raised");

  a_byte_swap: assert property (@(posedge i_clk)
    disable iff (i_rst)
    ctrl[CTRL_BYTE_HI] |=> o_analog[7:0] == $past(i_analog[15:8]))
    else $error("analogue byte order wrong");
endmodule : ofadc_core

// >>> design/ofadc_pkg.sv
package ofadc_pkg;
  // Register byte addresses (word aligned)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPEN_EN = 8'h04;
  localparam logic [7:0] ADDR_FAULT_ACT = 8'h08;
  localparam logic [7:0] ADDR_IDLE_ACT = 8'h0C;
  localparam logic [7:0] ADDR_DIAG = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_OUT_STATE = 8'h1C;

  // Control register fields
  localparam int CTRL_PRIO_SW = 0;
  localparam int CTRL_BYTE_HI = 1;
  localparam int CTRL_CI_MON = 2;
  localparam int CTRL_OUT_MON = 3;
  localparam int CTRL_SHORT_EN = 4;
  localparam int CTRL_MANUAL = 5;
  localparam int CTRL_W = 6;
  // Defaults: switch mode, low byte first, ci monitor on, out monitor off,
  // short detect on, automatic restart
  localparam logic [5:0] CTRL_RESET = 6'h14;

  // Diagnostic fields
  localparam int DIAG_CI = 0;
  localparam int DIAG_OUT = 1;
  localparam int DIAG_SHORT = 2;
  localparam int DIAG_OPEN = 3;
  localparam int DIAG_W = 4;

  // Per-channel output actions
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_HOLD = 2'h1;
  localparam logic [1:0] ACT_ON = 2'h2;

  typedef enum logic [1:0] {
    OFADC_RUN,
    OFADC_FAULT,
    OFADC_IDLE
  } ofadc_comm_t;

  typedef struct packed {
    logic ci_high;
    logic ci_low;
    logic out_high;
    logic out_low;
  } ofadc_supply_t;
endpackage : ofadc_pkg

// >>> verification/ofadc_net.sv
module ofadc_net (
  // Clock and wanted state
  input wire logic i_clk,
  input wire ofadc_pkg::ofadc_comm_t i_mode,
  input wire logic [7:0] i_cmd,
  // Lines into the block
  output logic o_fault,
  output logic o_idle,
  output logic [7:0] o_cmd
);
  import ofadc_pkg::*;
  logic [2:0] age;
  // Stale command stays put while the block syncs the state lines,
  // then toggles, so a hold cannot just follow it
  always_ff @(posedge i_clk) begin
    o_fault <= i_mode == OFADC_FAULT;
    o_idle <= i_mode == OFADC_IDLE;
    if (i_mode == OFADC_RUN) begin
      age <= 3'h0;
      o_cmd <= i_cmd;
    end else if (age < 3'h4) begin
      age <= age + 3'h1;
    end else begin
      o_cmd <= ~o_cmd;
    end
  end
endmodule : ofadc_net

// >>> verification/ofadc_core_tb.sv
module ofadc_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ofadc_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic rd = 1'b0;
  logic we = 1'b0;
  logic sh = 1'b0;
  logic hs = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [7:0] op = 8'h00;
  logic [7:0] cmd = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] q;
  logic [15:0] ana = 16'h1234;
  ofadc_supply_t sup = '0;
  ofadc_comm_t mode = OFADC_RUN;
  wire f, idl, wt, irq;
  wire [7:0] ncmd, v, oe;
  wire [31:0] rdat;
  wire [15:0] aout;
  wire [3:0] dg;
  int fail_count = 0;
  int n_compared = 0;
  ofadc_net ofadc_net_i (.i_clk(i_clk), .i_mode(mode), .i_cmd(cmd),
    .o_fault(f), .o_idle(idl), .o_cmd(ncmd));
  ofadc_core ofadc_core_i (.i_clk(i_clk), .i_rst(i_rst), .i_address(adr),
    .i_read(rd), .i_write(we), .i_writedata(wd), .o_readdata(rdat),
    .o_waitrequest(wt), .i_supply(sup), .i_short(sh), .i_open(op),
    .i_hold_switch(hs), .i_comm_fault(f), .i_comm_idle(idl),
    .i_out_cmd(ncmd), .i_analog(ana), .o_analog(aout), .o_valve(v),
    .o_diag(dg), .o_open_err(oe), .o_irq(irq));
  initial begin
    forever #20 i_clk = ~i_clk;
  end
  task tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    adr <= a;
    wd <= d;
    we <= 1'b1;
    @(posedge i_clk iff wt === 1'b0);
    we <= 1'b0;
  endtask : wr
  task rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    adr <= a;
    rd <= 1'b1;
    @(posedge i_clk iff wt === 1'b0);
    q = rdat;
    rd <= 1'b0;
    chk(q, e);
  endtask : rc
  task rst;
    @(posedge i_clk);
    i_rst <= 1'b1;
    tick(3);
    i_rst <= 1'b0;
  endtask : rst
  task t_reg;
    rc(ADDR_CTRL, 32'h14);
    rc(ADDR_OPEN_EN, 32'h0);
    rc(ADDR_FAULT_ACT, 32'h0);
    rc(ADDR_IDLE_ACT, 32'h0);
    wr(8'h40, 32'hFF);
    rc(8'h40, 32'h0);
    $display("test regs done");
  endtask : t_reg
  task t_byte;
    tick(4);
    chk(aout, 16'h1234);
    wr(ADDR_CTRL, 32'h16);
    tick(4);
    chk(aout, 16'h3412);
    wr(ADDR_CTRL, 32'h14);
    $display("test byte order done");
  endtask : t_byte
  task t_act;
    cmd <= 8'h0F;
    tick(6);
    mode <= OFADC_FAULT;
    tick(6);
    chk(v, 8'h00);
    mode <= OFADC_RUN;
    hs <= 1'b1;
    tick(6);
    mode <= OFADC_IDLE;
    tick(6);
    chk(v, 8'h0F);
    mode <= OFADC_RUN;
    wr(ADDR_FAULT_ACT, 32'hC6);
    wr(ADDR_IDLE_ACT, 32'hAA00);
    wr(ADDR_CTRL, 32'h15);
    tick(6);
    mode <= OFADC_FAULT;
    tick(6);
    chk(v, 8'h03);
    mode <= OFADC_RUN;
    tick(6);
    mode <= OFADC_IDLE;
    tick(6);
    chk(v, 8'hF0);
    mode <= OFADC_RUN;
    wr(ADDR_CTRL, 32'h14);
    $display("test output actions done");
  endtask : t_act
  task t_short;
    wr(ADDR_IRQ_MASK, 32'h4);
    sh <= 1'b1;
    tick(6);
    chk({irq, dg}, 5'h14);
    rc(ADDR_IRQ_STAT, 32'h4);
    tick(1);
    chk(irq, 1'b0);
    sh <= 1'b0;
    tick(6);
    chk(dg, 4'h0);
    wr(ADDR_CTRL, 32'h34);
    sh <= 1'b1;
    tick(6);
    sh <= 1'b0;
    tick(6);
    chk(dg, 4'h4);
    rst;
    chk(dg, 4'h0);
    wr(ADDR_CTRL, 32'h04);
    sh <= 1'b1;
    tick(6);
    chk(dg, 4'h0);
    sh <= 1'b0;
    wr(ADDR_CTRL, 32'h14);
    wr(ADDR_IRQ_MASK, 32'h4);
    $display("test short done");
  endtask : t_short
  task t_sup;
    sup.ci_low <= 1'b1;
    sup.out_high <= 1'b1;
    tick(6);
    chk({irq, dg}, 5'h01);
    wr(ADDR_CTRL, 32'h1C);
    tick(6);
    chk(dg, 4'h3);
    wr(ADDR_CTRL, 32'h18);
    tick(6);
    chk(dg, 4'h2);
    sup <= '0;
    tick(6);
    chk(dg, 4'h0);
    wr(ADDR_CTRL, 32'h14);
    $display("test supply done");
  endtask : t_sup
  task t_open;
    op <= 8'h81;
    tick(6);
    chk({oe, dg}, 12'h000);
    wr(ADDR_OPEN_EN, 32'h01);
    tick(6);
    rc(ADDR_DIAG, 32'h18);
    op <= 8'h00;
    tick(6);
    chk({oe, dg}, 12'h000);
    $display("test open done");
  endtask : t_open
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  // Run needs a few hundred cycles; this allows far more
  initial begin
    #1000000;
    fail_count++;
    wrap_up;
  end
  initial begin
    tick(3);
    i_rst <= 1'b0;
    t_reg;
    t_byte;
    t_act;
    t_short;
    t_sup;
    t_open;
    wrap_up;
  end
endmodule : ofadc_core_tb
